//--- shared/ebc_params.svh
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH
// Wait T-states before channel-ready sampling, or in state 15 for flash (each T-state = 2 clocks).
`define EBC_WAIT_16        4'd8
`define EBC_WAIT_8         4'd15
`define EBC_FLASH_WAIT     4'd2
`define EBC_TCNT_ZERO      4'd0
`define EBC_TCNT_ONE       4'd1
`define EBC_KBD_ADDR_BIT   2
`define EBC_A18_BIT        18
`define EBC_ADDR_W         24
`endif

//--- shared/ebc_pkg.sv
`default_nettype none
package ebc_pkg;
  // Cycle state machine states, numbered as the bus cycle states.
  typedef enum logic [3:0] {
    EBC_S0  = 4'b0000,
    EBC_S1  = 4'b0001,
    EBC_S2  = 4'b0010,
    EBC_S3  = 4'b0011,
    EBC_S5  = 4'b0101,
    EBC_S13 = 4'b1101,
    EBC_S15 = 4'b1111
  } ebc_state_type;
endpackage
`default_nettype wire

//--- verilog/ebc_ctrl.sv
`include "ebc_params.svh"
`default_nettype none
module ebc_ctrl
(
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Processor bus state and cycle qualifiers.
  input  wire logic                   first_state,
  input  wire logic                   pipelined_first_state,
  input  wire logic                   second_state,
  input  wire logic                   pipelined_second_state,
  input  wire logic                   phase,
  input  wire logic                   dram_cycle,
  input  wire logic                   mem_cycle,
  input  wire logic                   write_cycle,
  input  wire logic                   halt_cycle,
  input  wire logic                   shutdown_cycle,
  input  wire logic [`EBC_ADDR_W-1:0] addr,
  input  wire logic                   low_byte_en_n,
  input  wire logic                   high_byte_en_n,
  input  wire logic                   local_access_n,
  // Processor chip selects.
  input  wire logic                   low_region_select_n,
  input  wire logic                   top_region_select_n,
  input  wire logic                   kbd_cs_in_n,
  input  wire logic                   clock_chip_cs_n,
  input  wire logic                   disk_primary_cs_n,
  input  wire logic                   disk_secondary_cs_n,
  // Expansion bus inputs (asynchronous).
  input  wire logic                   io_wide_device_n,
  input  wire logic                   mem_wide_device_n,
  input  wire logic                   channel_ready,
  // Processor answers.
  output logic                        ready_n,
  output logic                        byte_size_req_n,
  output logic                        nmi,
  output logic                        data_buf_disable,
  // Expansion bus strobes.
  output logic                        addr_latch_strobe,
  output logic                        mem_read_n,
  output logic                        mem_write_n,
  output logic                        io_read_n,
  output logic                        io_write_n,
  // Peripheral selects.
  output logic                        flash_select_n,
  output logic                        flash_write_en_n,
  output logic                        flash_top_addr,
  output logic                        kbd_ctrl_select_n,
  output logic                        clock_chip_addr_strobe,
  output logic                        clock_chip_data_strobe,
  output logic                        disk_buf_high_en_n,
  output logic                        disk_buf_low_en_n
);
  import ebc_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic rdy_meta, rdy_sync, io16_meta, io16_sync, m16_meta, m16_sync;

  // Two flops before the state machine looks at any expansion-bus input.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_meta  <= 1'b1;
      rdy_sync  <= 1'b1;
      io16_meta <= 1'b1;
      io16_sync <= 1'b1;
      m16_meta  <= 1'b1;
      m16_sync  <= 1'b1;
    end else begin
      rdy_meta  <= channel_ready;
      rdy_sync  <= rdy_meta;
      io16_meta <= io_wide_device_n;
      io16_sync <= io16_meta;
      m16_meta  <= mem_wide_device_n;
      m16_sync  <= m16_meta;
    end
  end

  // ----------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------
  ebc_state_type state;
  ebc_state_type next_state;
  logic [3:0]    tcnt;
  logic [3:0]    next_tcnt;
  logic          wide;
  logic          flash_hit;
  logic          end_t;
  logic          start;
  logic          read_pend;
  logic          is_rtc;
  // A T-state ends on the second doubled-clock phase.
  assign end_t     = phase;
  assign flash_hit = !low_region_select_n || !top_region_select_n;
  assign start     = (first_state || pipelined_first_state) && !dram_cycle;
  // Wide when the resolved device answers 16-bit for this cycle type.
  function automatic logic is_wide(input logic m, input logic i16,
                                   input logic m16);
    is_wide = m ? !m16 : !i16;
  endfunction
  // Next state; every move happens on a T-state end.
  always_comb begin
    next_state = state;
    next_tcnt  = tcnt;
    if (end_t) begin
      case (state)
        EBC_S0: begin
          if (start) next_state = EBC_S1;
        end
        EBC_S1: begin
          if (flash_hit) begin
            next_state = EBC_S15;
            next_tcnt  = `EBC_FLASH_WAIT - `EBC_TCNT_ONE;
          end else if (!local_access_n) begin
            next_state = EBC_S0;
          end else if (halt_cycle) begin
            next_state = EBC_S15;
          end else begin
            next_state = EBC_S2;
          end
        end
        EBC_S2: next_state = EBC_S3;
        EBC_S3: next_state = EBC_S5;
        EBC_S5: begin
          next_state = EBC_S13;
          next_tcnt = is_wide(mem_cycle, io16_sync, m16_sync) ?
                      `EBC_WAIT_16 : `EBC_WAIT_8;
        end
        EBC_S13: begin
          if (tcnt != `EBC_TCNT_ZERO)
            next_tcnt = tcnt - `EBC_TCNT_ONE;
          else if (rdy_sync)
            next_state = EBC_S15;
        end
        EBC_S15: begin
          if (tcnt != `EBC_TCNT_ZERO)
            next_tcnt = tcnt - `EBC_TCNT_ONE;
          else
            next_state = EBC_S0;
        end
        default: next_state = EBC_S0;
      endcase
    end
  end
  // State and wait counter.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EBC_S0;
      tcnt  <= `EBC_TCNT_ZERO;
    end else begin
      state <= next_state;
      tcnt  <= next_tcnt;
    end
  end
  // Width resolved once, latched for byte-size and disk buffers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) wide <= 1'b0;
    else if (state == EBC_S5 && end_t)
      wide <= is_wide(mem_cycle, io16_sync, m16_sync);
  end

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  // Latch strobe: up entering state 1, down at end of 1 or mid state 2.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) addr_latch_strobe <= 1'b0;
    else if (state == EBC_S0 && end_t && start)
      addr_latch_strobe <= 1'b1;
    else if (state == EBC_S1 && end_t && next_state != EBC_S2)
      addr_latch_strobe <= 1'b0;
    else if (state == EBC_S2 && !end_t)
      addr_latch_strobe <= 1'b0;
  end
  // Commands: on at end of 2; writes off at end of 15, reads after 0.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_read_n  <= 1'b1;
      mem_write_n <= 1'b1;
      io_read_n   <= 1'b1;
      io_write_n  <= 1'b1;
      read_pend   <= 1'b0;
    end else if (state == EBC_S2 && end_t) begin
      mem_read_n  <= !(mem_cycle && !write_cycle);
      mem_write_n <= !(mem_cycle && write_cycle);
      io_read_n   <= !(!mem_cycle && !write_cycle);
      io_write_n  <= !(!mem_cycle && write_cycle);
    end else if (state == EBC_S15 && end_t && next_state == EBC_S0) begin
      mem_write_n <= 1'b1;
      io_write_n  <= 1'b1;
      read_pend   <= !mem_read_n || !io_read_n;
    end else if (state == EBC_S0 && end_t && read_pend) begin
      mem_read_n <= 1'b1;
      io_read_n  <= 1'b1;
      read_pend  <= 1'b0;
    end
  end
  // Ready: one T-state, changing one phase into the T-state.
  logic rdy_arm;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_arm <= 1'b0;
      ready_n <= 1'b1;
    end else begin
      rdy_arm <= state == EBC_S15 && end_t && next_state == EBC_S0;
      if (rdy_arm) ready_n <= 1'b0;
      else if (!end_t) ready_n <= 1'b1;
    end
  end
  // Byte-size request for a word cycle to a narrow device.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) byte_size_req_n <= 1'b1;
    else if (state == EBC_S0) byte_size_req_n <= 1'b1;
    else if (state == EBC_S13)
      byte_size_req_n <= !(!wide && !low_byte_en_n && !high_byte_en_n);
  end

  // ----------------------------------------------------------------
  // Peripheral selects
  // ----------------------------------------------------------------
  // Registered decode; one clock of latency against the selects.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_select_n    <= 1'b1;
      flash_write_en_n  <= 1'b1;
      flash_top_addr    <= 1'b0;
      kbd_ctrl_select_n <= 1'b1;
    end else begin
      flash_select_n   <= !flash_hit;
      flash_write_en_n <= !(flash_hit && write_cycle && state == EBC_S15);
      flash_top_addr   <= !top_region_select_n ? addr[`EBC_A18_BIT] :
                          !addr[`EBC_A18_BIT];
      // Low byte only, and address bit 2 picks 60h or 64h anyway.
      kbd_ctrl_select_n <= !(!kbd_cs_in_n && !low_byte_en_n);
    end
  end
  // Clock chip strobes follow the cycle; the flag clears in idle so a
  // later cycle to another device never inherits a stale address strobe.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_rtc                 <= 1'b0;
      clock_chip_addr_strobe <= 1'b0;
      clock_chip_data_strobe <= 1'b0;
    end else begin
      is_rtc <= state == EBC_S1 ? !clock_chip_cs_n : is_rtc && state != EBC_S0;
      clock_chip_addr_strobe <= !clock_chip_cs_n && next_state == EBC_S1 ||
                                is_rtc && state == EBC_S1;
      clock_chip_data_strobe <= is_rtc && (state == EBC_S3 ||
                                state == EBC_S5 || state == EBC_S13);
    end
  end
  // Disk buffers by byte lane and resolved width.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      disk_buf_high_en_n <= 1'b1;
      disk_buf_low_en_n  <= 1'b1;
    end else begin
      disk_buf_low_en_n  <= !((!disk_primary_cs_n || !disk_secondary_cs_n) &&
                             (state == EBC_S13 || state == EBC_S15) &&
                             !low_byte_en_n);
      disk_buf_high_en_n <= !((!disk_primary_cs_n || !disk_secondary_cs_n) &&
                             (state == EBC_S13 || state == EBC_S15) &&
                             !high_byte_en_n && wide);
    end
  end
  // Buffer disable after a second state; prevents turnaround clash.
  logic after_t2;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      after_t2         <= 1'b0;
      data_buf_disable <= 1'b0;
    end else begin
      if (end_t) after_t2 <= second_state || pipelined_second_state;
      data_buf_disable <= after_t2 && !second_state &&
                          !pipelined_second_state;
    end
  end
  // NMI held from shutdown until the next top-region select.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) nmi <= 1'b0;
    else if (shutdown_cycle) nmi <= 1'b1;
    else if (!top_region_select_n) nmi <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_flash_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      flash_hit |=> !flash_select_n;
  endproperty
  a_flash_sel: assert property (p_flash_sel)
    else $error("flash select missed");
  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
      state == EBC_S0 && end_t && start |=> state == EBC_S1;
  endproperty
  a_start: assert property (p_start)
    else $error("cycle did not start");
  property p_local;
    @(posedge ref_clk) disable iff (!rst_n)
      state == EBC_S1 && end_t && !flash_hit && !local_access_n
      |=> state == EBC_S0;
  endproperty
  a_local: assert property (p_local)
    else $error("local access not released");
  property p_flash_go;
    @(posedge ref_clk) disable iff (!rst_n)
      state == EBC_S1 && end_t && flash_hit |=> state == EBC_S15;
  endproperty
  a_flash_go: assert property (p_flash_go)
    else $error("flash did not go to fifteen");
  property p_ready_len;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(ready_n) |-> !ready_n ##1 !ready_n ##1 ready_n;
  endproperty
  a_ready_len: assert property (p_ready_len)
    else $error("ready width wrong");
  property p_write_end;
    @(posedge ref_clk) disable iff (!rst_n)
      state == EBC_S15 && next_state == EBC_S0 |=> io_write_n && mem_write_n;
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write strobe held too long");
  property p_hold13;
    @(posedge ref_clk) disable iff (!rst_n)
      state == EBC_S13 && tcnt == `EBC_TCNT_ZERO && !rdy_sync
      |=> state == EBC_S13;
  endproperty
  a_hold13: assert property (p_hold13)
    else $error("not-ready ignored");
  property p_nmi;
    @(posedge ref_clk) disable iff (!rst_n)
      shutdown_cycle |=> nmi;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi missed");
endmodule
`default_nettype wire

//--- verification/ebc_bus_model.sv
`default_nettype none
// ---------------------------------------------------------------
// Processor bus and expansion-bus peripheral stand-in.
// ---------------------------------------------------------------
module ebc_bus_model #(
  parameter logic [23:0] CLOCK_PORT = 24'h000070 // Plain default.
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Bench requests.
  input  wire logic        req,
  input  wire logic        self_end,
  input  wire logic        wide,
  input  wire logic [7:0]  hold_clks,
  input  wire logic        mem_cycle,
  input  wire logic [23:0] addr,
  // Controller answers.
  input  wire logic        ready_n,
  input  wire logic        cmd_on,
  // Bus states.
  output logic             phase,
  output logic             first_state,
  output logic             second_state,
  output logic             busy,
  // Selects and peripheral lines.
  output logic             kbd_cs_in_n,
  output logic             clock_chip_cs_n,
  output logic             disk_primary_cs_n,
  output logic             disk_secondary_cs_n,
  output logic             io_wide_device_n,
  output logic             mem_wide_device_n,
  output logic             channel_ready
);
  logic       req_q;
  logic       got_rdy;
  logic       io;
  logic [7:0] t2_clks;
  logic [7:0] low_cnt;

  // Chip selects decoded the way the processor is programmed.
  assign io = busy && !mem_cycle;
  assign kbd_cs_in_n = !(io && (addr[23:1] == 23'h30 ||
                                addr[23:1] == 23'h32));
  assign disk_primary_cs_n = !(io && addr[23:3] == 21'h3e);
  assign disk_secondary_cs_n = !(io && addr[23:1] == 23'h1fb);
  assign clock_chip_cs_n = !(io && addr[23:1] == CLOCK_PORT[23:1]);
  // Width lines have pull-ups, so a narrow device leaves them high.
  assign io_wide_device_n = !(io && wide);
  assign mem_wide_device_n = !(busy && mem_cycle && wide);

  // Sampling the request on the rising edge keeps the start race-free.
  always @(posedge ref_clk) begin
    req_q <= req;
    got_rdy <= second_state && (got_rdy || !ready_n);
  end

  // One T-state of first state, then second state until ready or a self_end timeout.
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      first_state <= 1'b0;
      second_state <= 1'b0;
      busy <= 1'b0;
      t2_clks <= 8'h00;
    end else begin
      phase <= ~phase;
      if (req_q && !busy && phase) begin
        first_state <= 1'b1;
        busy <= 1'b1;
      end else if (first_state && phase) begin
        first_state <= 1'b0;
        second_state <= 1'b1;
        t2_clks <= 8'h00;
      end else if (second_state) begin
        t2_clks <= t2_clks + 8'h01;
        if (phase && (got_rdy || (self_end && t2_clks > 8'h04))) begin
          second_state <= 1'b0;
          busy <= 1'b0;
        end
      end
    end
  end

  // A slow peripheral holds channel ready low after a command starts.
  always @(negedge ref_clk) begin
    if (!cmd_on) begin
      low_cnt <= 8'h00;
    end else if (low_cnt < hold_clks) begin
      low_cnt <= low_cnt + 8'h01;
    end
    channel_ready <= !(cmd_on && low_cnt < hold_clks);
  end
endmodule
`default_nettype wire

//--- verification/ebc_ctrl_tb.sv
`include "ebc_params.svh"
`default_nettype none
// ---------------------------------------------------------------
// Self-checking bench for the expansion bus cycle controller.
// ---------------------------------------------------------------
module ebc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] CLK_PORT = 24'h000070; // Plain default.
  logic        ref_clk, rst_n, req, self_end, wide, mon;
  logic [7:0]  hold_clks;
  logic        dram_cycle, mem_cycle, write_cycle, halt_cycle;
  logic        shutdown_cycle, low_byte_en_n, high_byte_en_n;
  logic        local_access_n, low_region_select_n, top_region_select_n;
  logic [23:0] addr;
  logic [15:0] clk_cnt, lat_cnt, cmd_cnt, rdy_cnt, rdy_at, r_base;
  logic [15:0] cmdc [4];
  logic [11:0] seen;
  int          err_total, num_checks;
  wire logic   phase, first_state, second_state, busy, kbd_cs_in_n;
  wire logic   clock_chip_cs_n, disk_primary_cs_n, disk_secondary_cs_n;
  wire logic   io_wide_device_n, mem_wide_device_n, channel_ready;
  wire logic   ready_n, byte_size_req_n, nmi, data_buf_disable;
  wire logic   addr_latch_strobe, mem_read_n, mem_write_n, io_read_n;
  wire logic   io_write_n, flash_select_n, flash_write_en_n;
  wire logic   flash_top_addr, kbd_ctrl_select_n, clock_chip_addr_strobe;
  wire logic   clock_chip_data_strobe, disk_buf_high_en_n;
  wire logic   disk_buf_low_en_n;
  wire logic [3:0] strb;
  assign strb = ~{mem_read_n, mem_write_n, io_read_n, io_write_n};

  ebc_ctrl u_ebc_ctrl (.ref_clk, .rst_n, .first_state,
    .pipelined_first_state(1'b0), .second_state,
    .pipelined_second_state(1'b0), .phase, .dram_cycle, .mem_cycle,
    .write_cycle, .halt_cycle, .shutdown_cycle, .addr, .low_byte_en_n,
    .high_byte_en_n, .local_access_n, .low_region_select_n,
    .top_region_select_n, .kbd_cs_in_n, .clock_chip_cs_n,
    .disk_primary_cs_n, .disk_secondary_cs_n, .io_wide_device_n,
    .mem_wide_device_n, .channel_ready, .ready_n, .byte_size_req_n, .nmi,
    .data_buf_disable, .addr_latch_strobe, .mem_read_n, .mem_write_n,
    .io_read_n, .io_write_n, .flash_select_n, .flash_write_en_n,
    .flash_top_addr, .kbd_ctrl_select_n, .clock_chip_addr_strobe,
    .clock_chip_data_strobe, .disk_buf_high_en_n, .disk_buf_low_en_n);

  ebc_bus_model #(.CLOCK_PORT(CLK_PORT)) u_ebc_bus_model (.ref_clk,
    .rst_n, .req, .self_end, .wide, .hold_clks, .mem_cycle, .addr,
    .ready_n, .cmd_on(|strb), .phase, .first_state, .second_state, .busy,
    .kbd_cs_in_n, .clock_chip_cs_n, .disk_primary_cs_n,
    .disk_secondary_cs_n, .io_wide_device_n, .mem_wide_device_n,
    .channel_ready);

  // Clock at 125 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cycle monitor; times count from the start of the bus cycle.
  always @(posedge ref_clk) begin
    if (!mon) begin
      {clk_cnt, lat_cnt, cmd_cnt, rdy_cnt, rdy_at} <= '0;
      seen <= '0;
    end else begin
      clk_cnt <= clk_cnt + 16'(busy);
      lat_cnt <= lat_cnt + 16'(addr_latch_strobe);
      cmd_cnt <= cmd_cnt + 16'(|strb);
      rdy_cnt <= rdy_cnt + 16'(!ready_n);
      if (rdy_at == 16'h0000 && !ready_n) rdy_at <= clk_cnt;
      seen <= seen | {strb, !byte_size_req_n, clock_chip_addr_strobe,
                      clock_chip_data_strobe, !disk_buf_high_en_n,
                      !disk_buf_low_en_n, !kbd_ctrl_select_n,
                      data_buf_disable, !flash_write_en_n};
    end
  end

  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic set_cyc(input logic m, input logic w,
                         input logic [23:0] a);
    mem_cycle = m;
    write_cycle = w;
    addr = a;
    {dram_cycle, halt_cycle, self_end} = 3'b000;
    {low_byte_en_n, high_byte_en_n, wide} = 3'b001;
    {local_access_n, low_region_select_n, top_region_select_n} = 3'b111;
    hold_clks = 8'h00;
  endtask

  // One bus cycle; the tail leaves room for the late ready release and buffer disable.
  task automatic run_cyc;
    int i;
    @(negedge ref_clk);
    mon = 1'b1;
    req = 1'b1;
    for (i = 0; i < 8 && busy !== 1'b1; i++) @(negedge ref_clk);
    req = 1'b0;
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge ref_clk);
    check("cycle end", busy, 1'b0);
    repeat (6) @(negedge ref_clk);
    mon = 1'b0;
  endtask

  // All four command kinds; reads hold one T-state past writes.
  task automatic t_kinds;
    for (int k = 0; k < 4; k++) begin
      set_cyc(k[1], k[0], 24'h000300);
      run_cyc();
      check("strobe kind", seen[11:8], 4'b1 << {k[1], ~k[0]});
      check("latch clocks", lat_cnt, 16'd3);
      check("ready clocks", rdy_cnt, 16'd2);
      check("narrow req", seen[7], 1'b0);
      cmdc[k] = cmd_cnt;
      if (k == 0) r_base = rdy_at;
      if (k == 0) check("buf disable", seen[1], 1'b1);
    end
    check("io read hold", cmdc[0] - cmdc[1], 16'd2);
    check("mem read hold", cmdc[2] - cmdc[3], 16'd2);
  endtask

  // Disk cycles, wide then narrow: wait counts and buffer enables.
  task automatic t_width;
    set_cyc(1'b0, 1'b0, 24'h0001f0);
    run_cyc();
    r_base = rdy_at;
    check("disk lanes wide", seen[4:3], 2'b11);
    set_cyc(1'b0, 1'b0, 24'h0001f0);
    wide = 1'b0;
    run_cyc();
    check("narrow extra", rdy_at - r_base,
          16'((`EBC_WAIT_8 - `EBC_WAIT_16) * 2));
    check("narrow req", seen[7], 1'b1);
    check("disk low lane", seen[3], 1'b1);
    check("disk high lane", seen[4], 1'b0);
  endtask

  // A slow peripheral stretches the cycle by whole T-states.
  task automatic t_hold;
    logic [15:0] d;
    set_cyc(1'b0, 1'b0, 24'h000300);
    hold_clks = 8'd80;
    run_cyc();
    d = rdy_at - r_base;
    check("hold whole", d[0], 1'b0);
    check("hold longer", 16'(d > 16'd1 && d < 16'd200), 16'd1);
  endtask

  // Flash in both regions: select, aliased top bit, no bus strobes.
  task automatic t_flash;
    for (int r = 0; r < 2; r++) begin
      set_cyc(1'b1, r[0], 24'h040000);
      {low_region_select_n, top_region_select_n} = {r[0], ~r[0]};
      run_cyc();
      check("flash select", flash_select_n, 1'b0);
      check("flash top", flash_top_addr, r[0]);
      check("flash latch", lat_cnt, 16'd2);
      check("flash strobes", seen[11:8], 4'h0);
      check("flash ready", rdy_cnt, 16'd2);
      check("flash write", seen[0], r[0]);
    end
    set_cyc(1'b0, 1'b0, 24'h000000);
    repeat (3) @(negedge ref_clk);
    check("flash idle", flash_select_n, 1'b1);
  endtask

  // Local, halt and memory-controller cycles.
  task automatic t_other;
    set_cyc(1'b0, 1'b0, 24'h000300);
    {local_access_n, self_end} = 2'b01;
    run_cyc();
    check("local ready", rdy_cnt, 16'd0);
    check("local strobes", seen[11:8], 4'h0);
    check("local latch", lat_cnt, 16'd2);
    set_cyc(1'b0, 1'b0, 24'h000300);
    halt_cycle = 1'b1;
    run_cyc();
    check("halt ready", rdy_cnt, 16'd2);
    check("halt strobes", seen[11:8], 4'h0);
    set_cyc(1'b1, 1'b0, 24'h000300);
    {dram_cycle, self_end} = 2'b11;
    run_cyc();
    check("dram latch", lat_cnt, 16'd0);
    check("dram ready", rdy_cnt, 16'd0);
  endtask

  // Clock chip and keyboard selects.
  task automatic t_periph;
    set_cyc(1'b0, 1'b0, CLK_PORT);
    run_cyc();
    check("clock strobes", seen[6:5], 2'b11);
    set_cyc(1'b0, 1'b0, 24'h000060);
    run_cyc();
    check("kbd low byte", seen[2], 1'b1);
    check("kbd no clock", seen[6:5], 2'b00);
    set_cyc(1'b0, 1'b0, 24'h000060);
    {low_byte_en_n, high_byte_en_n} = 2'b10;
    run_cyc();
    check("kbd high byte", seen[2], 1'b0);
  endtask

  // Shutdown raises the interrupt until the top region is selected.
  task automatic t_nmi;
    @(negedge ref_clk);
    shutdown_cycle = 1'b1;
    @(negedge ref_clk);
    shutdown_cycle = 1'b0;
    repeat (12) @(negedge ref_clk);
    check("nmi held", nmi, 1'b1);
    top_region_select_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    top_region_select_n = 1'b1;
    check("nmi cleared", nmi, 1'b0);
  endtask

  // Hang guard; the full run needs under a thousand clocks.
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {rst_n, req, mon, shutdown_cycle} = 4'b0000;
    set_cyc(1'b0, 1'b0, 24'h000000);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_kinds();
    t_width();
    t_hold();
    t_flash();
    t_other();
    t_periph();
    t_nmi();
    report_and_stop();
  end
endmodule
`default_nettype wire
